// *** duart_pkg.sv ***
/*
 Constants for the dual UART register decoder: register offsets, field positions,
 reset values and identity codes. Assumes a host bus with three address lines.
*/
package duart_pkg;
	localparam logic [2:0] ADR_HOLD = 3'h0;
	localparam logic [2:0] ADR_IEN = 3'h1;
	localparam logic [2:0] ADR_ISTAT = 3'h2;
	localparam logic [2:0] ADR_LCTL = 3'h3;
	localparam logic [2:0] ADR_MCTL = 3'h4;
	localparam logic [2:0] ADR_LSTAT = 3'h5;
	localparam logic [2:0] ADR_MSTAT = 3'h6;
	localparam logic [2:0] ADR_SCRATCH = 3'h7;
	localparam logic [7:0] ENH_PAGE_KEY = 8'hbf;
	localparam int LCTL_DIV_BIT = 7;
	localparam int EFN_GATE_BIT = 4;
	localparam logic [7:0] IEN_BASE_MASK = 8'h0f;
	localparam logic [7:0] QCTL_BASE_MASK = 8'hcf;
	localparam logic [7:0] MCTL_BASE_MASK = 8'h1f;
	localparam logic [7:0] ISTAT_BASE_MASK = 8'hcf;
	localparam logic [7:0] ALTF_MASK = 8'h07;
	localparam logic [7:0] FRAC_MASK = 8'h3f;
	localparam logic [7:0] RST_LCTL = 8'h00;
	localparam logic [7:0] RST_ZERO = 8'h00;
	// Arbitrary identity values
	localparam logic [7:0] DEF_REVISION = 8'h01;
	localparam logic [7:0] DEF_IDENT = 8'h5a;
endpackage : duart_pkg

// *** duart_regs.sv ***
/*
 One channel's register bank and page decoder for a dual UART.
 Assumes a host bus synchronous to sys_clk with one-cycle read and write strobes;
 the receive, transmit and modem logic sit outside and feed status in.
*/
// Operation
// - Address lines pick register, select picks channel
// - Address 0 reads rx holding, writes tx
// - Divisor page maps 0/1 to divisor bytes
// - Divisor page, gate clear: alternate function at 2
// - Divisor page, gate set: fractional divisor at 2
// - Zero divisor: address 0 reads revision
// - Zero divisor: address 1 reads ident
// - Address 1 is interrupt enable normally
// - Address 2 reads status, writes queue control
// - Queue control fields decoded on write
// - Address 3 always line control
// - Address 4 modem control outside enhanced page
// - Address 5 line status unless key
// - Address 6 reads modem status
// - Address 7 scratch pad register
// - Key page: address 2 enhanced function
// - Key page: 4 and 5 resume chars
// - Key page: 6 and 7 pause chars
// - Enhanced bits gated by enhanced bit four
`timescale 1ns/1ns
module duart_regs
	import duart_pkg::*;
#(
	parameter logic [7:0] REVISION = DEF_REVISION,
	parameter logic [7:0] IDENT = DEF_IDENT
)
(
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic chan_sel,
	input wire logic [2:0] addr,
	input wire logic rd_stb,
	input wire logic wr_stb,
	input wire logic [7:0] wr_data,
	input wire logic [7:0] rx_holding,
	input wire logic [3:0] int_source,
	input wire logic [1:0] int_flow,
	input wire logic [7:0] line_status,
	input wire logic [7:0] modem_status,
	output logic [7:0] rd_data_ff,
	output logic rd_valid_ff,
	output logic [7:0] tx_holding_ff,
	output logic tx_load_ff,
	output logic [7:0] line_control_ff,
	output logic [7:0] interrupt_enable_ff,
	output logic [7:0] modem_control_ff,
	output logic [7:0] enhanced_function_ff,
	output logic [7:0] divisor_low_ff,
	output logic [7:0] divisor_high_ff,
	output logic [7:0] divisor_fraction_ff,
	output logic [7:0] alt_function_ff,
	output logic fifo_enable_ff,
	output logic dma_mode_ff,
	output logic [1:0] tx_trigger_ff,
	output logic [1:0] rx_trigger_ff,
	output logic rx_fifo_reset_ff,
	output logic tx_fifo_reset_ff,
	output logic [7:0] resume_char_one_ff,
	output logic [7:0] resume_char_two_ff,
	output logic [7:0] pause_char_one_ff,
	output logic [7:0] pause_char_two_ff,
	output logic [7:0] scratch_pad_ff
);
	logic key_page;
	logic div_page;
	logic norm_page;
	logic gate;
	logic div_zero;
	logic rd;
	logic wr;
	logic [7:0] nxt_rd_data;

	// Enhanced page wins over divisor page since the key also sets the divisor bit
	assign key_page = (line_control_ff == ENH_PAGE_KEY);
	assign div_page = line_control_ff[LCTL_DIV_BIT] && !key_page;
	assign norm_page = !line_control_ff[LCTL_DIV_BIT];
	assign gate = enhanced_function_ff[EFN_GATE_BIT];
	assign div_zero = (divisor_low_ff == RST_ZERO) && (divisor_high_ff == RST_ZERO);
	assign rd = rd_stb && chan_sel;
	assign wr = wr_stb && chan_sel;

	function automatic logic [7:0] gated(input logic [7:0] v, input logic [7:0] base, input logic g);
		gated = g ? v : (v & base);
	endfunction : gated

	function automatic logic hit(input logic [2:0] a, input logic [2:0] ref_a);
		hit = (a == ref_a);
	endfunction : hit

	always_comb
	begin
		nxt_rd_data = RST_ZERO;
		unique case (addr)
			ADR_HOLD: nxt_rd_data = div_page ? (div_zero ? REVISION : divisor_low_ff) : rx_holding;
			ADR_IEN: nxt_rd_data = div_page ? (div_zero ? IDENT : divisor_high_ff)
				: gated(interrupt_enable_ff, IEN_BASE_MASK, gate);
			ADR_ISTAT:
			begin
				if (key_page)
					nxt_rd_data = enhanced_function_ff;
				else if (div_page)
					nxt_rd_data = gate ? (divisor_fraction_ff & FRAC_MASK) : alt_function_ff;
				else
					nxt_rd_data = gated({{2{fifo_enable_ff}}, int_flow, int_source}, ISTAT_BASE_MASK, gate);
			end
			ADR_LCTL: nxt_rd_data = line_control_ff;
			ADR_MCTL: nxt_rd_data = key_page ? resume_char_one_ff : gated(modem_control_ff, MCTL_BASE_MASK, gate);
			ADR_LSTAT: nxt_rd_data = key_page ? resume_char_two_ff : line_status;
			ADR_MSTAT: nxt_rd_data = key_page ? pause_char_one_ff : modem_status;
			ADR_SCRATCH: nxt_rd_data = key_page ? pause_char_two_ff : scratch_pad_ff;
		endcase
	end

	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			rd_data_ff <= RST_ZERO;
			rd_valid_ff <= 1'b0;
		end
		else
		begin
			rd_valid_ff <= rd;
			if (rd)
				rd_data_ff <= nxt_rd_data;
		end
	end

	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			tx_holding_ff <= RST_ZERO;
			tx_load_ff <= 1'b0;
		end
		else
		begin
			// The key value has the divisor bit set as well, so it must never start a transmit
			tx_load_ff <= wr && hit(addr, ADR_HOLD) && norm_page;
			if (wr && hit(addr, ADR_HOLD) && norm_page)
				tx_holding_ff <= wr_data;
		end
	end

	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			line_control_ff <= RST_LCTL;
			scratch_pad_ff <= RST_ZERO;
		end
		else if (wr)
		begin
			if (hit(addr, ADR_LCTL))
				line_control_ff <= wr_data;
			if (hit(addr, ADR_SCRATCH) && !key_page)
				scratch_pad_ff <= wr_data;
		end
	end

	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			divisor_low_ff <= RST_ZERO;
			divisor_high_ff <= RST_ZERO;
			alt_function_ff <= RST_ZERO;
			divisor_fraction_ff <= RST_ZERO;
		end
		else if (wr && div_page)
		begin
			if (hit(addr, ADR_HOLD))
				divisor_low_ff <= wr_data;
			if (hit(addr, ADR_IEN))
				divisor_high_ff <= wr_data;
			if (hit(addr, ADR_ISTAT) && !gate)
				alt_function_ff <= wr_data & ALTF_MASK;
			if (hit(addr, ADR_ISTAT) && gate)
				divisor_fraction_ff <= wr_data & FRAC_MASK;
		end
	end

	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			interrupt_enable_ff <= RST_ZERO;
			modem_control_ff <= RST_ZERO;
		end
		else if (wr && !div_page && !key_page)
		begin
			if (hit(addr, ADR_IEN))
				interrupt_enable_ff <= gated(wr_data, IEN_BASE_MASK, gate);
			if (hit(addr, ADR_MCTL))
				modem_control_ff <= gated(wr_data, MCTL_BASE_MASK, gate);
		end
		else if (wr && div_page && hit(addr, ADR_MCTL))
			modem_control_ff <= gated(wr_data, MCTL_BASE_MASK, gate);
	end

	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			fifo_enable_ff <= 1'b0;
			dma_mode_ff <= 1'b0;
			tx_trigger_ff <= 2'h0;
			rx_trigger_ff <= 2'h0;
			rx_fifo_reset_ff <= 1'b0;
			tx_fifo_reset_ff <= 1'b0;
		end
		else
		begin
			// Queue resets are self-clearing pulses
			rx_fifo_reset_ff <= 1'b0;
			tx_fifo_reset_ff <= 1'b0;
			if (wr && hit(addr, ADR_ISTAT) && !div_page && !key_page)
			begin
				fifo_enable_ff <= wr_data[0];
				rx_fifo_reset_ff <= wr_data[1];
				tx_fifo_reset_ff <= wr_data[2];
				dma_mode_ff <= wr_data[3];
				tx_trigger_ff <= gate ? wr_data[5:4] : 2'h0;
				rx_trigger_ff <= wr_data[7:6];
			end
		end
	end

	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			enhanced_function_ff <= RST_ZERO;
			resume_char_one_ff <= RST_ZERO;
			resume_char_two_ff <= RST_ZERO;
			pause_char_one_ff <= RST_ZERO;
			pause_char_two_ff <= RST_ZERO;
		end
		else if (wr && key_page)
		begin
			if (hit(addr, ADR_ISTAT))
				enhanced_function_ff <= wr_data;
			if (hit(addr, ADR_MCTL))
				resume_char_one_ff <= wr_data;
			if (hit(addr, ADR_LSTAT))
				resume_char_two_ff <= wr_data;
			if (hit(addr, ADR_MSTAT))
				pause_char_one_ff <= wr_data;
			if (hit(addr, ADR_SCRATCH))
				pause_char_two_ff <= wr_data;
		end
	end

	// Access kinds by page; some of the properties below start from one of them
	sequence s_wr_normal;
		wr && norm_page;
	endsequence

	sequence s_wr_divisor;
		wr && div_page;
	endsequence

	sequence s_wr_key;
		wr && key_page;
	endsequence

	sequence s_rd_normal;
		rd && norm_page;
	endsequence

	sequence s_rd_divisor;
		rd && div_page;
	endsequence

	sequence s_rd_key;
		rd && key_page;
	endsequence

	a_lctl_always: assert property (@(posedge sys_clk) disable iff (reset)
		wr && addr == ADR_LCTL |=> line_control_ff == $past(wr_data))
		else $error("line control not written");
	a_lctl_read: assert property (@(posedge sys_clk) disable iff (reset)
		rd && addr == ADR_LCTL |=> rd_data_ff == $past(line_control_ff))
		else $error("line control not returned");
	a_key_efn: assert property (@(posedge sys_clk) disable iff (reset)
		s_wr_key ##0 addr == ADR_ISTAT |=> enhanced_function_ff == $past(wr_data))
		else $error("enhanced function not written");
	a_efn_read: assert property (@(posedge sys_clk) disable iff (reset)
		s_rd_key ##0 addr == ADR_ISTAT |=> rd_data_ff == $past(enhanced_function_ff))
		else $error("enhanced function not returned");
	a_rev_read: assert property (@(posedge sys_clk) disable iff (reset)
		s_rd_divisor ##0 div_zero && addr == ADR_HOLD |=> rd_valid_ff && rd_data_ff == REVISION)
		else $error("revision not returned");
	a_ident_read: assert property (@(posedge sys_clk) disable iff (reset)
		s_rd_divisor ##0 div_zero && addr == ADR_IEN |=> rd_data_ff == IDENT)
		else $error("ident not returned");
	a_ien_gate: assert property (@(posedge sys_clk) disable iff (reset)
		s_rd_normal ##0 !gate && addr == ADR_IEN |=> rd_data_ff[7:4] == 4'h0)
		else $error("gated enable bits read nonzero");
	a_ien_write: assert property (@(posedge sys_clk) disable iff (reset)
		s_wr_normal ##0 addr == ADR_IEN |=> interrupt_enable_ff[3:0] == $past(wr_data[3:0]))
		else $error("interrupt enable not written");
	a_frac_top: assert property (@(posedge sys_clk) disable iff (reset)
		divisor_fraction_ff[7:6] == 2'h0)
		else $error("fraction top bits nonzero");
	a_frac_write: assert property (@(posedge sys_clk) disable iff (reset)
		s_wr_divisor ##0 gate && addr == ADR_ISTAT |=> divisor_fraction_ff == ($past(wr_data) & FRAC_MASK))
		else $error("fraction not written");
	a_altf_write: assert property (@(posedge sys_clk) disable iff (reset)
		s_wr_divisor ##0 !gate && addr == ADR_ISTAT |=> alt_function_ff == ($past(wr_data) & ALTF_MASK))
		else $error("alternate function not written");
	a_dll_write: assert property (@(posedge sys_clk) disable iff (reset)
		s_wr_divisor ##0 addr == ADR_HOLD |=> divisor_low_ff == $past(wr_data))
		else $error("divisor low not written");
	a_dlm_write: assert property (@(posedge sys_clk) disable iff (reset)
		s_wr_divisor ##0 addr == ADR_IEN |=> divisor_high_ff == $past(wr_data))
		else $error("divisor high not written");
	a_dll_read: assert property (@(posedge sys_clk) disable iff (reset)
		s_rd_divisor ##0 !div_zero && addr == ADR_HOLD |=> rd_data_ff == $past(divisor_low_ff))
		else $error("divisor low not returned");
	a_tx_load: assert property (@(posedge sys_clk) disable iff (reset)
		s_wr_normal ##0 addr == ADR_HOLD |=> tx_load_ff ##1 (!tx_load_ff || $past(wr, 1)))
		else $error("transmit load missing");
	a_no_tx_load: assert property (@(posedge sys_clk) disable iff (reset)
		!(wr && norm_page && addr == ADR_HOLD) |=> !tx_load_ff)
		else $error("transmit load outside normal page");
	a_rx_read: assert property (@(posedge sys_clk) disable iff (reset)
		s_rd_normal ##0 addr == ADR_HOLD |=> rd_data_ff == $past(rx_holding))
		else $error("receive data not returned");
	a_istat_read: assert property (@(posedge sys_clk) disable iff (reset)
		s_rd_normal ##0 addr == ADR_ISTAT
		|=> rd_data_ff[3:0] == $past(int_source) && rd_data_ff[7:6] == {2{$past(fifo_enable_ff)}})
		else $error("interrupt status not returned");
	a_qctl_strobe: assert property (@(posedge sys_clk) disable iff (reset)
		s_wr_normal ##0 addr == ADR_ISTAT
		|=> rx_fifo_reset_ff == $past(wr_data[1]) && tx_fifo_reset_ff == $past(wr_data[2]))
		else $error("queue reset strobes wrong");
	a_qctl_pulse: assert property (@(posedge sys_clk) disable iff (reset)
		!(wr && norm_page && addr == ADR_ISTAT) |=> !rx_fifo_reset_ff && !tx_fifo_reset_ff)
		else $error("queue reset strobe held");
	a_trig_gate: assert property (@(posedge sys_clk) disable iff (reset)
		s_wr_normal ##0 !gate && addr == ADR_ISTAT |=> tx_trigger_ff == 2'h0)
		else $error("gated trigger bits written");
	a_mctl_write: assert property (@(posedge sys_clk) disable iff (reset)
		wr && !key_page && addr == ADR_MCTL |=> modem_control_ff[4:0] == $past(wr_data[4:0]))
		else $error("modem control not written");
	a_mctl_gate: assert property (@(posedge sys_clk) disable iff (reset)
		wr && !key_page && !gate && addr == ADR_MCTL |=> modem_control_ff[7:5] == 3'h0)
		else $error("gated modem control bits written");
	a_no_select: assert property (@(posedge sys_clk) disable iff (reset)
		!chan_sel |=> !rd_valid_ff && !tx_load_ff)
		else $error("unselected channel answered");
	a_read_pulse: assert property (@(posedge sys_clk) disable iff (reset)
		rd |=> rd_valid_ff)
		else $error("read not answered");
	a_lstat_read: assert property (@(posedge sys_clk) disable iff (reset)
		rd && !key_page && addr == ADR_LSTAT |=> rd_data_ff == $past(line_status))
		else $error("line status not returned");
	a_mstat_read: assert property (@(posedge sys_clk) disable iff (reset)
		rd && !key_page && addr == ADR_MSTAT |=> rd_data_ff == $past(modem_status))
		else $error("modem status not returned");
	a_scratch_hold: assert property (@(posedge sys_clk) disable iff (reset)
		wr && !key_page && addr == ADR_SCRATCH |=> scratch_pad_ff == $past(wr_data))
		else $error("scratch pad not written");
	a_resume_one: assert property (@(posedge sys_clk) disable iff (reset)
		s_wr_key ##0 addr == ADR_MCTL |=> resume_char_one_ff == $past(wr_data))
		else $error("first resume char not written");
	a_resume_two: assert property (@(posedge sys_clk) disable iff (reset)
		s_wr_key ##0 addr == ADR_LSTAT |=> resume_char_two_ff == $past(wr_data))
		else $error("second resume char not written");
	a_pause_one: assert property (@(posedge sys_clk) disable iff (reset)
		s_wr_key ##0 addr == ADR_MSTAT |=> pause_char_one_ff == $past(wr_data))
		else $error("first pause char not written");
	a_pause_read: assert property (@(posedge sys_clk) disable iff (reset)
		s_rd_key ##0 addr == ADR_SCRATCH |=> rd_data_ff == $past(pause_char_two_ff))
		else $error("second pause char not returned");
endmodule : duart_regs

// *** duart_host.sv ***
/*
 Host bus model: one register access at a time.
 Assumes strobes are sampled on the rising edge of sys_clk.
*/
`timescale 1ns/1ns
module duart_host
	import duart_pkg::*;
(
	input wire logic sys_clk,
	output logic chan_sel,
	output logic [2:0] addr,
	output logic rd_stb,
	output logic wr_stb,
	output logic [7:0] wr_data,
	input wire logic [7:0] rd_data_ff,
	input wire logic rd_valid_ff
);
	logic on = 1'b1;
	assign chan_sel = on;
	initial
	begin
		addr = 3'h0;
		rd_stb = 1'b0;
		wr_stb = 1'b0;
		wr_data = 8'h00;
	end
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		#1;
		addr = a;
		wr_data = d;
		wr_stb = 1'b1;
		@(posedge sys_clk);
		#1;
		wr_stb = 1'b0;
		// Released data must not look valid
		wr_data = ~d;
	endtask : wr
	task automatic rd(input logic [2:0] a, output logic [7:0] d, output logic ok);
		int i;
		@(posedge sys_clk);
		#1;
		addr = a;
		rd_stb = 1'b1;
		@(posedge sys_clk);
		#1;
		rd_stb = 1'b0;
		ok = 1'b0;
		d = 8'h00;
		for (i = 0; i < 4; i++)
		begin
			if (rd_valid_ff === 1'b1)
			begin
				ok = 1'b1;
				d = rd_data_ff;
				break;
			end
			@(posedge sys_clk);
			#1;
		end
	endtask : rd
endmodule : duart_host

// *** dual_uart_register_decode_tb_top.sv ***
/*
 Self-checking bench for one channel's register bank.
 Assumes the host model drives the bus; status inputs are held levels.
*/
`timescale 1ns/1ns
module dual_uart_register_decode_tb_top
	import duart_pkg::*;
;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic chan_sel, rd_stb, wr_stb, rd_valid_ff, fifo_enable_ff, dma_mode_ff;
	logic tx_load_ff, rx_fifo_reset_ff, tx_fifo_reset_ff;
	logic [1:0] tx_trigger_ff;
	logic [2:0] addr;
	logic [7:0] wr_data, rd_data_ff, tx_holding_ff, line_control_ff, enhanced_function_ff, scratch_pad_ff;
	logic [1:0] rx_trigger_ff;
	logic [7:0] rx_holding = 8'h3c;
	logic [3:0] int_source = 4'h1;
	logic [1:0] int_flow = 2'h3;
	logic [7:0] line_status = 8'h60;
	logic [7:0] modem_status = 8'hb0;
	int mismatches = 0;
	int cmp_count = 0;
	// Rows: line control, address, write data, expected read
	logic [31:0] rows [21] = '{32'h00_01_ff_0f, 32'h00_07_a5_a5, 32'h00_04_ff_1f, 32'h00_05_00_60,
		32'h00_06_00_b0, 32'h00_00_77_3c, 32'h00_02_c9_c1, 32'h80_00_12_12, 32'h80_01_34_34,
		32'h80_02_ff_07, 32'h80_03_80_80, 32'hbf_02_10_10, 32'hbf_04_11_11, 32'hbf_05_22_22,
		32'hbf_06_33_33, 32'hbf_07_44_44, 32'h80_02_ff_3f, 32'h00_01_ff_ff, 32'h00_04_ff_ff,
		32'h00_02_c9_f1, 32'h80_00_00_00};
	always #20 sys_clk = ~sys_clk;
	duart_host host (.sys_clk(sys_clk), .chan_sel(chan_sel), .addr(addr), .rd_stb(rd_stb), .wr_stb(wr_stb),
		.wr_data(wr_data), .rd_data_ff(rd_data_ff), .rd_valid_ff(rd_valid_ff));
	duart_regs dut (.sys_clk(sys_clk), .reset(reset), .chan_sel(chan_sel), .addr(addr), .rd_stb(rd_stb),
		.wr_stb(wr_stb), .wr_data(wr_data), .rx_holding(rx_holding), .int_source(int_source),
		.int_flow(int_flow), .line_status(line_status), .modem_status(modem_status),
		.rd_data_ff(rd_data_ff), .rd_valid_ff(rd_valid_ff), .tx_holding_ff(tx_holding_ff), .tx_load_ff(tx_load_ff),
		.line_control_ff(line_control_ff), .interrupt_enable_ff(), .modem_control_ff(),
		.enhanced_function_ff(enhanced_function_ff), .divisor_low_ff(), .divisor_high_ff(),
		.divisor_fraction_ff(), .alt_function_ff(), .fifo_enable_ff(fifo_enable_ff),
		.dma_mode_ff(dma_mode_ff), .tx_trigger_ff(tx_trigger_ff), .rx_trigger_ff(rx_trigger_ff),
		.rx_fifo_reset_ff(rx_fifo_reset_ff), .tx_fifo_reset_ff(tx_fifo_reset_ff), .resume_char_one_ff(),
		.resume_char_two_ff(),
		.pause_char_one_ff(), .pause_char_two_ff(), .scratch_pad_ff(scratch_pad_ff));
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : conclude
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic rdchk(input logic [2:0] a, input logic [7:0] exp);
		logic [7:0] d;
		logic ok;
		host.rd(a, d, ok);
		if (ok !== 1'b1)
		begin
			mismatches++;
			$display("[FAIL] %0t no read answer", $time);
			conclude();
		end
		else
			check(d, exp);
	endtask : rdchk
	initial
	begin
		repeat (6) @(posedge sys_clk);
		#1;
		reset = 1'b0;
		check(line_control_ff, RST_LCTL);
		check(scratch_pad_ff, RST_ZERO);
		$display("test reset done");
		foreach (rows[i])
		begin
			host.wr(3'h3, rows[i][31:24]);
			host.wr(rows[i][18:16], rows[i][15:8]);
			rdchk(rows[i][18:16], rows[i][7:0]);
		end
		check(tx_holding_ff, 8'h77);
		check({7'h00, dma_mode_ff}, 8'h01);
		check({7'h00, fifo_enable_ff}, 8'h01);
		check({6'h00, rx_trigger_ff}, 8'h03);
		$display("test table done");
		// Both divisor bytes zero: identity codes replace them
		host.wr(3'h1, 8'h00);
		rdchk(3'h1, DEF_IDENT);
		rdchk(3'h0, DEF_REVISION);
		$display("test ident done");
		// Key page must not start a transmit; strobes stand for one cycle after the write
		host.wr(3'h3, ENH_PAGE_KEY);
		host.wr(3'h0, 8'h99);
		check({7'h00, tx_load_ff}, 8'h00);
		check(tx_holding_ff, 8'h77);
		host.wr(3'h3, 8'h00);
		host.wr(3'h2, 8'h36);
		check({6'h00, rx_fifo_reset_ff, tx_fifo_reset_ff}, 8'h03);
		check({6'h00, tx_trigger_ff}, 8'h03);
		host.wr(3'h0, 8'h5e);
		check({7'h00, tx_load_ff}, 8'h01);
		check(tx_holding_ff, 8'h5e);
		host.wr(3'h3, ENH_PAGE_KEY);
		host.wr(3'h2, 8'h00);
		host.wr(3'h3, 8'h00);
		rdchk(3'h1, 8'h0f);
		host.wr(3'h2, 8'h30);
		check({6'h00, tx_trigger_ff}, 8'h00);
		$display("test gated done");
		host.on = 1'b0;
		host.wr(3'h7, 8'h5c);
		host.on = 1'b1;
		rdchk(3'h7, 8'ha5);
		$display("test deselect done");
		@(posedge sys_clk);
		#1;
		reset = 1'b1;
		@(posedge sys_clk);
		#1;
		check(line_control_ff, RST_LCTL);
		check(enhanced_function_ff, RST_ZERO);
		reset = 1'b0;
		rdchk(3'h1, 8'h00);
		$display("test second reset done");
		conclude();
	end
endmodule : dual_uart_register_decode_tb_top
